// file: core/ee_cfg.svh
// ee_cfg.svh - offsets, codes and timing counts of the two-wire memory slave
// assumes: included by ee_pkg and the core module only
`ifndef EE_CFG_SVH
`define EE_CFG_SVH
`define EE_CLK_HZ    25000000
`define EE_TWR_US    5000
`define EE_WR_CYC    (`EE_TWR_US * (`EE_CLK_HZ / 1000000))
`define EE_MEM_AW    16
`define EE_PAGE_AW   7
`define EE_ID_AW     8
`define EE_SEL_MAIN  4'hA
`define EE_SEL_ID    4'hB
`define EE_LOCK_ABIT 10
`define EE_LOCK_DBIT 1
`define EE_PIN_IDLE  6'h30
`endif

// file: core/ee_pkg.sv
// ee_pkg - types of the two-wire memory slave
// assumes: ee_cfg.svh sits on the include path
`include "ee_cfg.svh"
package ee_pkg;
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_RX   = 5'h02,
		ST_ACK  = 5'h04,
		ST_TX   = 5'h08,
		ST_MACK = 5'h10
	} state_e;
	typedef enum logic [3:0] {
		PH_SEL  = 4'h1,
		PH_ADRH = 4'h2,
		PH_ADRL = 4'h4,
		PH_DATA = 4'h8
	} phase_e;
	typedef struct packed {
		logic       scl;
		logic       sda;
		logic       wp;
		logic [2:0] cs;
	} pins_s;
endpackage : ee_pkg

// file: core/ee_slave.sv
// ee_slave - two-wire serial slave in front of a 64K x 8 array and an id page
// assumes: pins arrive asynchronously; SDA has an external pull-up and the
// wire level is resolved outside from SDA_OE_N_O; bus clock at most 1 MHz
`timescale 1ns/1ps
`default_nettype none
`include "ee_cfg.svh"
module ee_slave
	import ee_pkg::*;
#(
	parameter int WR_CYC = `EE_WR_CYC
) (
	input  wire logic CORE_CLK_I,
	input  wire logic RST_I,
	input  wire logic SCL_I,
	input  wire logic SDA_I,
	output var  logic SDA_O,
	output var  logic SDA_OE_N_O,
	input  wire logic WP_I,
	input  wire logic CHIP_SELECT_BIT_ZERO_I,
	input  wire logic CHIP_SELECT_BIT_ONE_I,
	input  wire logic CHIP_SELECT_BIT_TWO_I,
	output var  logic BUSY_O,
	output var  logic STANDBY_O
);
	localparam int PAGE = 1 << `EE_PAGE_AW;
	localparam int TW   = $clog2(WR_CYC + 1);

	// the copy of one page takes PAGE cycles and must fit in the write time
	if (WR_CYC < PAGE + 1) begin : g_chk
		$error("WR_CYC too small for one page copy");
	end

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	logic [7:0] mem [0:(1 << `EE_MEM_AW) - 1];
	logic [7:0] idmem [0:(1 << `EE_ID_AW) - 1];
	logic [7:0] pbuf [0:PAGE - 1];

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	pins_s pin_raw;
	pins_s pin_m_r;
	pins_s pin_s_r;
	pins_s pin_d_r;

	// floating select inputs are pulled to zero at the pad
	assign pin_raw = '{scl: SCL_I, sda: SDA_I, wp: WP_I,
		cs: {CHIP_SELECT_BIT_TWO_I, CHIP_SELECT_BIT_ONE_I, CHIP_SELECT_BIT_ZERO_I}};

	// reset holds an idle bus image so no false start is seen on release
	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			pin_m_r <= pins_s'(`EE_PIN_IDLE);
			pin_s_r <= pins_s'(`EE_PIN_IDLE);
			pin_d_r <= pins_s'(`EE_PIN_IDLE);
		end else begin
			pin_m_r <= pin_raw;
			pin_s_r <= pin_m_r;
			pin_d_r <= pin_s_r;
		end
	end

	// ----------------------------------------------------------------
	// bus events
	// ----------------------------------------------------------------
	// with at most 1 MHz on the bus each clock half lasts a dozen cycles
	wire scl_rise = pin_s_r.scl & ~pin_d_r.scl;
	wire scl_fall = ~pin_s_r.scl & pin_d_r.scl;
	wire scl_hold = pin_s_r.scl & pin_d_r.scl;
	wire start_ev = scl_hold & pin_d_r.sda & ~pin_s_r.sda;
	wire stop_ev  = scl_hold & ~pin_d_r.sda & pin_s_r.sda;

	// ----------------------------------------------------------------
	// protocol state
	// ----------------------------------------------------------------
	state_e      state_r;
	phase_e      phase_r;
	logic [3:0]  bcnt_r;
	logic [7:0]  shift_r;
	logic        rd_r;
	logic        id_r;
	logic        mack_r;
	logic        oe_n_r;
	logic [15:0] addr_r;
	logic        busy_r;
	logic [7:0]  pidx_r;
	logic [TW-1:0] tmr_r;
	logic [PAGE-1:0] mask_r;
	logic [8:0]  wpage_r;
	logic        wid_r;
	logic        lock_r;
	logic        lock_pend_r;
	logic        standby_r;

	function automatic logic [15:0] page_inc(input logic [15:0] a);
		page_inc = {a[15:7], a[6:0] + 7'h01};
	endfunction : page_inc

	wire byte_done = (state_r == ST_RX) & scl_fall & (bcnt_r == 4'h8);
	wire sel_code  = (shift_r[7:4] == `EE_SEL_MAIN) | (shift_r[7:4] == `EE_SEL_ID);
	wire sel_ok    = sel_code & (shift_r[3:1] == pin_s_r.cs) & ~busy_r;
	wire sel_ev    = byte_done & (phase_r == PH_SEL);
	wire adrl_ev   = byte_done & (phase_r == PH_ADRL) & ~rd_r;
	wire wr_data_ev = byte_done & (phase_r == PH_DATA) & ~rd_r;
	wire lock_req  = id_r & addr_r[`EE_LOCK_ABIT] & shift_r[`EE_LOCK_DBIT];
	wire wr_allow  = ~pin_s_r.wp & ~(id_r & lock_r);
	wire wr_keep_ev = wr_data_ev & wr_allow & ~lock_req;
	wire lock_ev   = wr_data_ev & wr_allow & lock_req;
	wire load_tx   = scl_fall & (((state_r == ST_ACK) & rd_r) | ((state_r == ST_MACK) & mack_r));
	wire [7:0] rd_byte = id_r ? idmem[addr_r[7:0]] : mem[addr_r];
	wire commit    = stop_ev & ~busy_r & ((|mask_r) | lock_pend_r);
	wire prog_we   = busy_r & ~pidx_r[7] & mask_r[pidx_r[6:0]];
	wire prog_done = busy_r & (tmr_r == TW'(WR_CYC - 1));

	// ----------------------------------------------------------------
	// byte engine
	// ----------------------------------------------------------------
	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			state_r <= ST_IDLE;
			phase_r <= PH_SEL;
			bcnt_r  <= 4'h0;
			shift_r <= 8'h00;
			rd_r    <= 1'b0;
			id_r    <= 1'b0;
			mack_r  <= 1'b0;
			oe_n_r  <= 1'b1;
			addr_r  <= 16'h0000;
		end else if (start_ev) begin
			state_r <= ST_RX;
			phase_r <= PH_SEL;
			bcnt_r  <= 4'h0;
			oe_n_r  <= 1'b1;
		end else if (stop_ev) begin
			state_r <= ST_IDLE;
			oe_n_r  <= 1'b1;
		end else if (load_tx) begin
			// a read hands out the byte at the pointer, then moves on
			state_r <= ST_TX;
			bcnt_r  <= 4'h0;
			shift_r <= rd_byte;
			oe_n_r  <= rd_byte[7];
			addr_r  <= addr_r + 16'h0001;
		end else begin
			unique case (state_r)
				ST_IDLE: begin
					oe_n_r <= 1'b1;
				end
				ST_RX: begin
					if (scl_rise) begin
						shift_r <= {shift_r[6:0], pin_s_r.sda};
						bcnt_r  <= bcnt_r + 4'h1;
					end else if (byte_done) begin
						state_r <= ST_ACK;
						oe_n_r  <= 1'b0;
						unique case (phase_r)
							PH_SEL: begin
								if (sel_ok) begin
									rd_r    <= shift_r[0];
									id_r    <= shift_r[4];
									phase_r <= PH_ADRH;
								end else begin
									// busy or not addressed: leave SDA released
									state_r <= ST_IDLE;
									oe_n_r  <= 1'b1;
								end
							end
							PH_ADRH: begin
								addr_r[15:8] <= shift_r;
								phase_r      <= PH_ADRL;
							end
							PH_ADRL: begin
								addr_r[7:0] <= shift_r;
								phase_r     <= PH_DATA;
							end
							PH_DATA: begin
								addr_r <= page_inc(addr_r);
							end
						endcase
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						state_r <= ST_RX;
						bcnt_r  <= 4'h0;
						oe_n_r  <= 1'b1;
					end
				end
				ST_TX: begin
					if (scl_fall) begin
						if (bcnt_r == 4'h7) begin
							state_r <= ST_MACK;
							oe_n_r  <= 1'b1;
						end else begin
							shift_r <= {shift_r[6:0], 1'b0};
							oe_n_r  <= shift_r[6];
							bcnt_r  <= bcnt_r + 4'h1;
						end
					end
				end
				ST_MACK: begin
					if (scl_rise) begin
						mack_r <= ~pin_s_r.sda;
					end else if (scl_fall) begin
						state_r <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// page buffer and lock request
	// ----------------------------------------------------------------
	always_ff @(posedge CORE_CLK_I) begin
		if (wr_keep_ev) begin
			pbuf[addr_r[6:0]] <= shift_r;
		end
	end

	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			mask_r      <= '0;
			lock_pend_r <= 1'b0;
			wpage_r     <= 9'h000;
			wid_r       <= 1'b0;
		end else if (prog_done) begin
			mask_r      <= '0;
			lock_pend_r <= 1'b0;
		end else if (adrl_ev) begin
			mask_r  <= '0;
			wpage_r <= {addr_r[15:8], shift_r[7]};
			wid_r   <= id_r;
		end else if (wr_keep_ev) begin
			mask_r[addr_r[6:0]] <= 1'b1;
		end else if (lock_ev) begin
			lock_pend_r <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// self-timed programming
	// ----------------------------------------------------------------
	// the page is copied one byte a cycle while the timer, started at the
	// stop, runs out the full write time so polling behaves like the real cell
	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			busy_r <= 1'b0;
			pidx_r <= 8'h00;
			tmr_r  <= '0;
			lock_r <= 1'b0;
		end else if (commit) begin
			busy_r <= 1'b1;
			pidx_r <= 8'h00;
			tmr_r  <= '0;
		end else if (busy_r) begin
			tmr_r <= tmr_r + TW'(1);
			if (~pidx_r[7]) begin
				pidx_r <= pidx_r + 8'h01;
			end
			if (prog_done) begin
				busy_r <= 1'b0;
				lock_r <= lock_r | lock_pend_r;
			end
		end
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (prog_we & wid_r) begin
			idmem[{wpage_r[0], pidx_r[6:0]}] <= pbuf[pidx_r[6:0]];
		end else if (prog_we) begin
			mem[{wpage_r, pidx_r[6:0]}] <= pbuf[pidx_r[6:0]];
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			standby_r <= 1'b1;
		end else begin
			standby_r <= (state_r == ST_IDLE) & ~busy_r;
		end
	end

	assign SDA_O      = 1'b0;
	assign SDA_OE_N_O = oe_n_r;
	assign BUSY_O     = busy_r;
	assign STANDBY_O  = standby_r;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (RST_I);

	a_sda_low_only: assert property (SDA_O == 1'b0)
		else $error("data line driven high");
	a_wr_time_bound: assert property (busy_r |-> tmr_r < TW'(WR_CYC))
		else $error("programming overran write time");
	a_busy_nack: assert property (sel_ev && busy_r |=> state_r == ST_IDLE && oe_n_r)
		else $error("select acknowledged while busy");
	a_sel_match: assert property ($rose(state_r == ST_ACK) && phase_r == PH_ADRH
		|-> shift_r[7:5] == 3'h5 && shift_r[3:1] == pin_s_r.cs && !oe_n_r)
		else $error("acknowledge without select match");
	a_wp_block: assert property (wr_data_ev && pin_s_r.wp |=> mask_r == $past(mask_r))
		else $error("write accepted under protect");
	a_id_locked: assert property (wr_data_ev && id_r && lock_r |=> mask_r == $past(mask_r))
		else $error("locked id page accepted a write");
	a_page_wrap: assert property (wr_data_ev |=> addr_r[15:7] == $past(addr_r[15:7])
		&& addr_r[6:0] == $past(addr_r[6:0]) + 7'h01)
		else $error("page pointer left its page");
	a_start_rx: assert property (start_ev |=> state_r == ST_RX && phase_r == PH_SEL
		&& bcnt_r == 4'h0)
		else $error("start did not open a select byte");
	a_stop_idle: assert property (stop_ev && !busy_r && !(|mask_r) && !lock_pend_r
		|-> ##2 STANDBY_O)
		else $error("no standby after stop");
	a_stop_prog: assert property (commit |=> busy_r ##1 !STANDBY_O)
		else $error("stop did not start programming");
endmodule : ee_slave
`default_nettype wire

// file: verification/tb.sv
// tb - self-checking bench of the two-wire memory slave
// assumes: ee_pkg compiled first; tw_master stands in for the bus master
`timescale 1ns/1ps
`default_nettype none
module tb;
	import ee_pkg::*;
	localparam int WR_CYC = 200;
	logic       clk, rst, wp, scl, m_low, oe_n, sda_o, busy, stby, sda;
	logic [2:0] cs;
	logic [7:0] wbuf [0:3];
	logic [7:0] rbuf [0:3];
	int         n_fail, checks_done;
	// open drain: either party pulls low, the pull-up gives the high level
	assign sda = ~m_low & (oe_n | sda_o);
	ee_slave #(.WR_CYC(WR_CYC)) ee_slave_inst (.CORE_CLK_I(clk), .RST_I(rst), .SCL_I(scl), .SDA_I(sda),
		.SDA_O(sda_o), .SDA_OE_N_O(oe_n), .WP_I(wp), .CHIP_SELECT_BIT_ZERO_I(cs[0]),
		.CHIP_SELECT_BIT_ONE_I(cs[1]), .CHIP_SELECT_BIT_TWO_I(cs[2]), .BUSY_O(busy), .STANDBY_O(stby));
	tw_master tw_master_inst (.SCL_O(scl), .LOW_O(m_low), .SDA_I(sda));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic final_report();
		if (n_fail == 0 && checks_done > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : final_report
	task automatic send(input logic [3:0] k, input logic [15:0] adr, input int n);
		logic a;
		tw_master_inst.start();
		tw_master_inst.wr({k, cs, 1'b0}, a);
		chk(8'(a), 8'h01);
		tw_master_inst.wr(adr[15:8], a);
		tw_master_inst.wr(adr[7:0], a);
		chk(8'(a), 8'h01);
		for (int i = 0; i < n; i++) tw_master_inst.wr(wbuf[i], a);
		tw_master_inst.stop();
		cyc(3);
	endtask : send
	task automatic get(input logic [3:0] k, input logic [15:0] adr, input int n);
		logic a;
		tw_master_inst.start();
		tw_master_inst.wr({k, cs, 1'b0}, a);
		tw_master_inst.wr(adr[15:8], a);
		tw_master_inst.wr(adr[7:0], a);
		tw_master_inst.start();
		tw_master_inst.wr({k, cs, 1'b1}, a);
		chk(8'(a), 8'h01);
		for (int i = 0; i < n; i++) tw_master_inst.rd(i == n - 1, rbuf[i]);
		tw_master_inst.stop();
		cyc(3);
	endtask : get
	task automatic probe(input logic [7:0] s, input logic exp_ack);
		logic a;
		tw_master_inst.start();
		tw_master_inst.wr(s, a);
		tw_master_inst.stop();
		cyc(3);
		chk(8'(a), 8'(exp_ack));
		chk(8'(stby), 8'h01);
	endtask : probe
	task automatic wait_idle();
		int k;
		k = 0;
		while (busy !== 1'b0 && k < WR_CYC + 20) begin
			cyc(1);
			k++;
		end
		chk(8'(k < WR_CYC + 20), 8'h01);
		if (k >= WR_CYC + 20) final_report();
		cyc(2);
		chk(8'(stby), 8'h01);
	endtask : wait_idle
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_page();
		logic a;
		wbuf = '{8'h11, 8'h22, 8'h33, 8'h00};
		send(4'hA, 16'h1200, 3);
		chk(8'(busy), 8'h01);
		chk(8'(stby), 8'h00);
		tw_master_inst.start();
		tw_master_inst.wr({4'hA, cs, 1'b0}, a);
		tw_master_inst.stop();
		chk(8'(a), 8'h00);
		wait_idle();
		// two bytes from the last slot: the second wraps onto the page's first byte
		wbuf = '{8'h44, 8'h55, 8'h00, 8'h00};
		send(4'hA, 16'h127F, 2);
		wait_idle();
		get(4'hA, 16'h1200, 3);
		chk(rbuf[0], 8'h55);
		chk(rbuf[1], 8'h22);
		chk(rbuf[2], 8'h33);
		get(4'hA, 16'h127F, 1);
		chk(rbuf[0], 8'h44);
	endtask : t_page
	task automatic t_wp();
		wp = 1'b1;
		wbuf[0] = 8'hEE;
		send(4'hA, 16'h1201, 1);
		chk(8'(busy), 8'h00);
		wp = 1'b0;
		get(4'hA, 16'h1201, 1);
		chk(rbuf[0], 8'h22);
	endtask : t_wp
	task automatic t_sel();
		probe({4'h9, cs, 1'b0}, 1'b0);
		probe({4'hA, cs ^ 3'b001, 1'b0}, 1'b0);
		for (int v = 0; v < 8; v++) begin
			cs = 3'(v);
			cyc(4);
			probe({4'hA, cs, 1'b0}, 1'b1);
		end
		cs = 3'b101;
		cyc(4);
	endtask : t_sel
	task automatic t_id();
		wbuf[0] = 8'h5A;
		send(4'hB, 16'h0010, 1);
		wait_idle();
		get(4'hB, 16'h0010, 1);
		chk(rbuf[0], 8'h5A);
		// lock request: id page, address bit 10 and data bit 1 set
		wbuf[0] = 8'h02;
		send(4'hB, 16'h0400, 1);
		chk(8'(busy), 8'h01);
		wait_idle();
		wbuf[0] = 8'hA5;
		send(4'hB, 16'h0010, 1);
		chk(8'(busy), 8'h00);
		get(4'hB, 16'h0010, 1);
		chk(rbuf[0], 8'h5A);
	endtask : t_id
	initial begin
		repeat (60000) @(posedge clk);
		n_fail++;
		final_report();
	end
	initial begin
		rst = 1'b1;
		wp = 1'b0;
		cs = 3'b101;
		n_fail = 0;
		checks_done = 0;
		cyc(6);
		chk({5'h00, oe_n, busy, stby}, 8'h05);
		cyc(6);
		rst = 1'b0;
		cyc(4);
		t_page();
		t_wp();
		t_sel();
		t_id();
		final_report();
	end
endmodule : tb
`default_nettype wire

// file: verification/tw_master.sv
// tw_master - behavioural two-wire bus master for the memory slave
// assumes: tasks entered 1 ns after a core clock edge; the line has a pull-up
`timescale 1ns/1ps
`default_nettype none
module tw_master (
	output var  logic SCL_O,
	output var  logic LOW_O,
	input  wire logic SDA_I
);
	// scl low 200 ns, high 120 ns; sda moves 40 ns after the fall so it is never seen racing scl
	// the bus runs faster than in service to keep runs short; each half still spans several core cycles
	initial begin
		SCL_O = 1'b1;
		LOW_O = 1'b0;
	end
	task automatic bit_out(input logic b);
		SCL_O = 1'b0;
		#40 LOW_O = ~b;
		#160 SCL_O = 1'b1;
		#120;
	endtask : bit_out
	task automatic bit_in(output logic b);
		SCL_O = 1'b0;
		#40 LOW_O = 1'b0;
		#160 SCL_O = 1'b1;
		#60 b = SDA_I;
		#60;
	endtask : bit_in
	task automatic start();
		SCL_O = 1'b0;
		#40 LOW_O = 1'b0;
		#160 SCL_O = 1'b1;
		#80 LOW_O = 1'b1;
		#120;
	endtask : start
	task automatic stop();
		SCL_O = 1'b0;
		#40 LOW_O = 1'b1;
		#160 SCL_O = 1'b1;
		#80 LOW_O = 1'b0;
		#320;
	endtask : stop
	task automatic wr(input logic [7:0] d, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			bit_out(d[i]);
		end
		bit_in(b);
		ack = ~b;
	endtask : wr
	task automatic rd(input logic last, output logic [7:0] d);
		for (int i = 7; i >= 0; i--) begin
			bit_in(d[i]);
		end
		bit_out(last);
	endtask : rd
endmodule : tw_master
`default_nettype wire
